/* core/btsc_pkg.sv */
// Package for the bit-test-skip-if-clear execution block.
// Assumes a 16-bit instruction word and an 8-bit data memory with 12-bit addresses.
package btsc_pkg;
    localparam int          INSTR_W     = 16;
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 12;
    localparam int          BANK_W      = 4;
    localparam logic [3:0]  OPC_BTSC    = 4'hb;
    localparam int          OPC_HI      = 15;
    localparam int          OPC_LO      = 12;
    localparam int          BSEL_HI     = 11;
    localparam int          BSEL_LO     = 9;
    localparam int          BANKF_POS   = 8;
    localparam int          FADR_HI     = 7;
    localparam int          FADR_LO     = 0;
    // Quick-access bank: low half maps to bank 0, high half to the top bank.
    localparam logic [7:0]  ACC_SPLIT   = 8'h80;
    localparam logic [3:0]  ACC_HI_BANK = 4'hf;
    localparam logic [3:0]  ACC_LO_BANK = 4'h0;
    localparam logic [1:0]  NOP_ONE     = 2'h1;
    localparam logic [1:0]  NOP_TWO     = 2'h2;
    localparam logic [1:0]  NOP_NONE    = 2'h0;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} btsc_phase_t;
endpackage : btsc_pkg

/* core/btsc_addr_res.sv */
// Data-memory address resolver for the banked operand field.
// Assumes the bank select value is stable across the instruction cycle.
`timescale 1ns/1ps
module btsc_addr_res
    import btsc_pkg::*;
(
    input  wire logic [7:0]        fileAddr,
    input  wire logic              bankFlag,
    input  wire logic [BANK_W-1:0] bankSel,
    output logic [ADDR_W-1:0]      dataAddr
);
    // The quick-access bank ignores bank select entirely.
    always_comb begin
        if (bankFlag) begin
            dataAddr = {bankSel, fileAddr}; // RQ5
        end else if (fileAddr < ACC_SPLIT) begin
            dataAddr = {ACC_LO_BANK, fileAddr}; // RQ4
        end else begin
            dataAddr = {ACC_HI_BANK, fileAddr}; // RQ4
        end
    end
endmodule : btsc_addr_res

/* core/btsc_exec.sv */
// Execution control for the bit-test-skip-if-clear instruction.
// Assumes the core pulses cycleStart once per four-clock cycle (phases are counted here) and that the fetch
// pipeline flags whether the prefetched word starts a two-word instruction.
`timescale 1ns/1ps
// Operation
// [RQ1] Decode opcode 1011, bit, bank flag, address
// [RQ2] Skip next instruction when tested bit clear
// [RQ3] Discard prefetch, one no-operation cycle substituted
// [RQ4] Bank flag zero selects quick-access bank
// [RQ5] Bank flag one uses bank select register
// [RQ6] Two-word skipped instruction costs two no-operations
// [RQ7] Bit field picks bit; flags untouched
module btsc_exec
    import btsc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               cycleStart,
    input  wire logic [INSTR_W-1:0] instrWord,
    input  wire logic               instrValid,
    input  wire logic               nextIsTwoWord,
    input  wire logic [BANK_W-1:0]  bankSel,
    input  wire logic [DATA_W-1:0]  readData,
    output logic [ADDR_W-1:0]       dataAddr,
    output logic                    dataRead,
    output logic                    discardFetch,
    output logic                    nopCycle,
    output logic                    skipTaken,
    output logic                    statusWrite
);
    btsc_phase_t         phase_q, phase_d;
    logic [1:0]          nopLeft_q, nopLeft_d;
    logic                active_q, active_d;
    logic [2:0]          bitSel_q, bitSel_d;
    logic                skip_q, skip_d;
    logic                discard_q, discard_d;
    logic                nopNow_q, nopNow_d;
    logic                isOurs;

    // Opcode match on the leading nibble.
    assign isOurs = instrValid && (instrWord[OPC_HI:OPC_LO] == OPC_BTSC); // RQ1

    btsc_addr_res uAddr (
        .fileAddr (instrWord[FADR_HI:FADR_LO]),
        .bankFlag (instrWord[BANKF_POS]),
        .bankSel  (bankSel),
        .dataAddr (dataAddr)
    );

    // The operand is read from Q1 through Q3 of the test cycle, dropping once the bit is tested.
    assign dataRead    = active_q;
    // This instruction never touches the arithmetic status flags.
    assign statusWrite = 1'b0; // RQ7
    // Marks the whole substituted cycle, so the core sees which execute cycle was emptied.
    assign nopCycle    = nopNow_q; // RQ3
    assign discardFetch = discard_q;
    assign skipTaken   = skip_q;

    // Next-state logic: phase counter, test latch and the skip sequencer.
    // The bit is tested at Q3 so the read data has settled since Q2.
    always_comb begin
        phase_d   = phase_q;
        nopLeft_d = nopLeft_q;
        active_d  = active_q;
        bitSel_d  = bitSel_q;
        nopNow_d  = nopNow_q;
        skip_d    = 1'b0;
        discard_d = 1'b0;
        case (phase_q)
            Q1: phase_d = Q2;
            Q2: phase_d = Q3;
            Q3: phase_d = Q4;
            Q4: phase_d = Q1;
            default: phase_d = Q1;
        endcase
        if (cycleStart) begin
            phase_d = Q1;
            if (nopLeft_q != NOP_NONE) begin
                // A refused word opens a substituted cycle; the flag holds until the next cycleStart.
                nopLeft_d = nopLeft_q - NOP_ONE;
                nopNow_d  = 1'b1; // RQ3
                active_d  = 1'b0;
            end else begin
                nopNow_d = 1'b0;
                active_d = isOurs; // RQ1
                bitSel_d = instrWord[BSEL_HI:BSEL_LO];
            end
        end
        if (active_q && phase_q == Q3) begin
            active_d = 1'b0;
            if (!readData[bitSel_q]) begin // RQ2 RQ7
                skip_d    = 1'b1;
                discard_d = 1'b1; // RQ3
                nopLeft_d = nextIsTwoWord ? NOP_TWO : NOP_ONE; // RQ6
            end
        end
    end

    // Registers; synchronous reset to idle.
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q   <= Q1;
            nopLeft_q <= NOP_NONE;
            active_q  <= 1'b0;
            bitSel_q  <= 3'h0;
            skip_q    <= 1'b0;
            discard_q <= 1'b0;
            nopNow_q  <= 1'b0;
        end else begin
            phase_q   <= phase_d;
            nopLeft_q <= nopLeft_d;
            active_q  <= active_d;
            bitSel_q  <= bitSel_d;
            skip_q    <= skip_d;
            discard_q <= discard_d;
            nopNow_q  <= nopNow_d;
        end
    end

    // Test edge of a taken instruction with the selected bit clear.
    sequence clearTest_s;
        active_q && phase_q == Q3 && !readData[bitSel_q];
    endsequence

    // Test edge of a taken instruction with the selected bit set.
    sequence setTest_s;
        active_q && phase_q == Q3 && readData[bitSel_q];
    endsequence

    // A cycleStart that offers this opcode while no substituted cycle is owed.
    sequence takeStart_s;
        cycleStart && nopLeft_q == NOP_NONE && instrValid && instrWord[OPC_HI:OPC_LO] == OPC_BTSC;
    endsequence

    // The operand read stands through Q1 to Q3 and drops once the bit is tested.
    sequence readWindow_s;
        dataRead [*3] ##1 !dataRead;
    endsequence

    // A clear bit raises the skip and the flush together, one clock after the test.
    skip_on_clear_a: assert property (@(posedge clk) disable iff (reset) // RQ2
        clearTest_s |=> skipTaken && discardFetch)
        else $error("Clear bit did not cause a skip.");

    // A set bit lets the next instruction run and owes no substituted cycle.
    no_skip_set_a: assert property (@(posedge clk) disable iff (reset) // RQ2
        setTest_s |=> !skipTaken && !discardFetch && nopLeft_q == NOP_NONE)
        else $error("Set bit caused a skip.");

    // A one-word successor costs one substituted cycle.
    one_nop_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        (clearTest_s and !nextIsTwoWord) |=> nopLeft_q == NOP_ONE)
        else $error("Single-word skip not one nop.");

    // A two-word successor costs two, which makes three cycles in all.
    two_nop_a: assert property (@(posedge clk) disable iff (reset) // RQ6
        (clearTest_s and nextIsTwoWord) |=> nopLeft_q == NOP_TWO)
        else $error("Two-word skip not two nops.");

    // The opcode is taken at its cycleStart and the test cycle begins.
    opcode_decode_a: assert property (@(posedge clk) disable iff (reset) // RQ1
        takeStart_s |=> active_q)
        else $error("Opcode not recognised.");

    // Any other word, or one marked not valid, leaves the block idle.
    foreign_op_a: assert property (@(posedge clk) disable iff (reset) // RQ1
        cycleStart && !(instrValid && instrWord[OPC_HI:OPC_LO] == OPC_BTSC) |=> !active_q)
        else $error("Foreign word taken as a test.");

    // A word offered while a substituted cycle is owed is refused, and the cycle is flagged.
    refuse_nop_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        cycleStart && nopLeft_q != NOP_NONE |=> !active_q && nopCycle)
        else $error("Word taken in a no-op cycle.");

    // The flag drops at the first cycleStart with nothing more owed.
    nop_end_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        cycleStart && nopLeft_q == NOP_NONE |=> !nopCycle)
        else $error("No-op flag outlived its cycle.");

    // A taken test reads its operand for three clocks only.
    read_window_a: assert property (@(posedge clk) disable iff (reset) // RQ1
        takeStart_s |=> readWindow_s)
        else $error("Operand read window wrong.");

    // The skip pulse stands for one clock only, so the pipeline flushes once.
    pulse_once_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        skipTaken |=> !skipTaken)
        else $error("Skip pulse too long.");

    // Skip and flush never part company.
    skip_pair_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        discardFetch == skipTaken)
        else $error("Skip and flush differ.");

    // Every skip leaves a substituted cycle owed.
    nop_owed_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        skipTaken |-> nopLeft_q != NOP_NONE)
        else $error("Skip without a no-op cycle.");

    // Quick-access low half lands in the bottom bank whatever bank select holds.
    access_low_a: assert property (@(posedge clk) disable iff (reset) // RQ4
        !instrWord[BANKF_POS] && instrWord[FADR_HI:FADR_LO] < ACC_SPLIT
            |-> dataAddr[ADDR_W-1:DATA_W] == ACC_LO_BANK)
        else $error("Quick bank low half wrong.");

    // Quick-access high half lands in the top bank whatever bank select holds.
    access_high_a: assert property (@(posedge clk) disable iff (reset) // RQ4
        !instrWord[BANKF_POS] && instrWord[FADR_HI:FADR_LO] >= ACC_SPLIT
            |-> dataAddr[ADDR_W-1:DATA_W] == ACC_HI_BANK)
        else $error("Quick bank high half wrong.");

    // A set bank flag takes the bank from the bank select register.
    banked_addr_a: assert property (@(posedge clk) disable iff (reset) // RQ5
        instrWord[BANKF_POS] |-> dataAddr[ADDR_W-1:DATA_W] == bankSel)
        else $error("Bank select not used.");

    // The register offset passes through unchanged in both bank modes.
    offset_kept_a: assert property (@(posedge clk) disable iff (reset) // RQ4 RQ5
        dataAddr[DATA_W-1:0] == instrWord[FADR_HI:FADR_LO])
        else $error("Register offset altered.");

    // The bit select is latched from the word taken at cycleStart.
    bit_latch_a: assert property (@(posedge clk) disable iff (reset) // RQ7
        takeStart_s |=> bitSel_q == $past(instrWord[BSEL_HI:BSEL_LO]))
        else $error("Bit select not latched.");

    // The status flags are never written by this instruction.
    no_flags_a: assert property (@(posedge clk) disable iff (reset) // RQ7
        !statusWrite)
        else $error("Status written.");

    // Phase count restarts at every cycleStart so the test lands on Q3.
    phase_sync_a: assert property (@(posedge clk) disable iff (reset) // RQ2
        cycleStart |=> phase_q == Q1)
        else $error("Phase not resynchronised.");
endmodule : btsc_exec

/* dv/btsc_exec_bench.sv */
// Bench for the skip-if-clear execution block: counts pulses per instruction.
// Assumes cycleStart every 4 clocks and no-op cycles of 4 clocks each.
`timescale 1ns/1ps
module btsc_exec_bench;
    import btsc_pkg::*;
    logic               clk, reset, cycleStart, instrValid, nextIsTwoWord;
    logic [INSTR_W-1:0] instrWord;
    logic [BANK_W-1:0]  bankSel;
    logic [DATA_W-1:0]  readData;
    logic [ADDR_W-1:0]  dataAddr;
    logic               dataRead, discardFetch, nopCycle, skipTaken, statusWrite;
    int                 n_mismatch, comparisons, ticks, skipCnt, dropCnt, nopCnt, readCnt, statCnt;

    btsc_exec u_btsc_exec (.clk(clk), .reset(reset), .cycleStart(cycleStart), .instrWord(instrWord),
        .instrValid(instrValid), .nextIsTwoWord(nextIsTwoWord), .bankSel(bankSel), .readData(readData),
        .dataAddr(dataAddr), .dataRead(dataRead), .discardFetch(discardFetch), .nopCycle(nopCycle),
        .skipTaken(skipTaken), .statusWrite(statusWrite));

    // Free-running clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Counts output activity per clock; the ceiling cuts a hang short.
    // Sampled on the falling edge, away from the rising edge where tasks drive and clear the counts.
    always @(negedge clk) begin
        ticks++;
        if (ticks > 3000) begin
            n_mismatch++;
            close_out();
        end else begin
            skipCnt += (skipTaken === 1'b1);
            dropCnt += (discardFetch === 1'b1);
            nopCnt  += (nopCycle === 1'b1);
            readCnt += (dataRead === 1'b1);
            statCnt += (statusWrite !== 1'b0);
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // One instruction cycle of four clocks, with the word offered at its Q1.
    task automatic cyc(input logic [15:0] w, input logic [7:0] rd);
        @(posedge clk);
        cycleStart <= 1'b1;
        instrWord  <= w;
        readData   <= rd;
        @(posedge clk);
        cycleStart <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : cyc

    // The word is offered twice; the repeat is refused when it lands in a no-op cycle.
    task automatic run(input logic [15:0] w, input logic [7:0] rd, input logic two, input logic [3:0] bank,
                       input logic [11:0] addr, input int skips, input int nops, input int reads);
        bankSel       <= bank;
        nextIsTwoWord <= two;
        {skipCnt, dropCnt, nopCnt, readCnt, statCnt} = '0;
        cyc(w, rd);
        #1 check("data address", dataAddr, addr);
        cyc(w, rd);
        repeat (3) cyc(16'h0000, 8'hff);
        check("skip pulses", skipCnt, skips);
        check("discard pulses", dropCnt, skips);
        check("no-op clocks", nopCnt, 4 * nops);
        check("read clocks", readCnt, reads);
        check("status writes", statCnt, 0);
    endtask : run

    task automatic test_skip_and_bank();
        run(16'hb534, 8'hfb, 1'b0, 4'h5, 12'h534, 1, 1, 3);
        run(16'hb534, 8'h04, 1'b0, 4'h5, 12'h534, 0, 0, 6);
        run(16'hb534, 8'hfb, 1'b1, 4'h5, 12'h534, 1, 2, 3);
        run(16'hb434, 8'hff, 1'b0, 4'h5, 12'h034, 0, 0, 6);
        run(16'hb4a5, 8'hff, 1'b0, 4'h5, 12'hfa5, 0, 0, 6);
        run(16'ha534, 8'h00, 1'b0, 4'h5, 12'h534, 0, 0, 0);
        instrValid <= 1'b0;
        run(16'hb534, 8'h00, 1'b0, 4'h5, 12'h534, 0, 0, 0);
        instrValid <= 1'b1;
    endtask : test_skip_and_bank

    // Each bit position alone is clear, so only the selected one may cause a skip.
    task automatic test_bit_select();
        for (int b = 0; b < 8; b++) begin
            run({4'hb, b[2:0], 1'b1, 8'h10}, ~(8'h01 << b), 1'b0, 4'h2, 12'h210, 1, 1, 3);
            run({4'hb, b[2:0], 1'b1, 8'h10}, 8'h01 << b, 1'b0, 4'h2, 12'h210, 0, 0, 6);
        end
    endtask : test_bit_select

    // Reset for three clocks, then the scenarios.
    initial begin
        reset         = 1'b1;
        cycleStart    = 1'b0;
        instrValid    = 1'b1;
        nextIsTwoWord = 1'b0;
        instrWord     = 16'h0000;
        bankSel       = 4'h0;
        readData      = 8'h00;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1 check("outputs in reset", {skipTaken, discardFetch, nopCycle, dataRead}, 0);
        @(posedge clk);
        test_skip_and_bank();
        test_bit_select();
        close_out();
    end
endmodule : btsc_exec_bench
